// ==== tb/tb_top.sv ====
// Self-checking bench for the up/down counter top.
`timescale 1ns/1ps
`include "ubc_params.svh"
module tb_top;
	typedef struct packed {logic [3:0] start; logic down; logic [3:0] next; logic term;} ubc_row_s;
	logic                ref_clk, rst, clk_en, count_clock, count_en_n, count_down;
	logic                preset_load_n, terminal_flag, ripple_clock_n, irq;
	ubc_pkg::ubc_count_t preset_data;
	logic [3:0]          count_value, upper_count, snap, wstrb;
	logic [31:0]         awaddr, wdata, araddr, rdata, rd;
	logic                awvalid, awready, wvalid, wready, bvalid, bready;
	logic                arvalid, arready, rvalid, rready;
	logic [1:0]          bresp, rresp, resp;
	int                  miscompares, checks;
	ubc_row_s            rows [6] = '{'{4'hE, 1'h0, 4'hF, 1'h1}, '{4'hF, 1'h0, 4'h0, 1'h0},
		'{4'h0, 1'h1, 4'hF, 1'h0}, '{4'h1, 1'h1, 4'h0, 1'h1}, '{4'h7, 1'h0, 4'h8, 1'h0},
		'{4'h8, 1'h1, 4'h7, 1'h0}};

	ubc_top dut (.ref_clk, .rst, .clk_en, .count_clock, .count_en_n, .count_down,
		.preset_load_n, .preset_data, .count_value, .terminal_flag, .ripple_clock_n, .irq,
		.s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
		.s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
		.s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
		.s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
		.s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
		.s_axil_rvalid(rvalid), .s_axil_rready(rready));
	ubc_upper_stage upper (.rst, .ripple_clock_n, .upper_count);

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		if (miscompares == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Two ref_clk cycles high then low: the count moves while the clock is still
	// high, so the ripple clock cannot glitch when the clock falls.
	task automatic pulse;
		@(posedge ref_clk) count_clock <= 1'h1;
		repeat (2) @(posedge ref_clk);
		count_clock <= 1'h0;
		@(posedge ref_clk) #1;
	endtask
	// Ready and valid are read just after the edge, before its updates land.
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw, pb;
		pa = 1'h1;
		pw = 1'h1;
		pb = 1'h1;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int i = 0; i < 40 && pb; i++) begin
			@(posedge ref_clk);
			if (pa && awready) begin
				awvalid <= 1'h0;
				pa = 1'h0;
			end
			if (pw && wready) begin
				wvalid <= 1'h0;
				pw = 1'h0;
			end
			if (bvalid) begin
				resp = bresp;
				bready <= 1'h0;
				pb = 1'h0;
			end
		end
		if (pb) begin
			miscompares++;
			test_done();
		end
		cmp(resp, er);
	endtask
	task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic pa, pr;
		pa = 1'h1;
		pr = 1'h1;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int i = 0; i < 40 && pr; i++) begin
			@(posedge ref_clk);
			if (pa && arready) begin
				arvalid <= 1'h0;
				pa = 1'h0;
			end
			if (rvalid) begin
				rd = rdata;
				resp = rresp;
				rready <= 1'h0;
				pr = 1'h0;
			end
		end
		if (pr) begin
			miscompares++;
			test_done();
		end
		cmp(rd, ed);
		cmp(resp, er);
	endtask

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		{clk_en, count_clock, count_en_n, count_down, preset_load_n} = 5'h11;
		// Non-blocking, so every reset process, the stage model too, sees the edge.
		rst <= 1'h1;
		{preset_data, wstrb, awaddr, wdata, araddr} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		miscompares = 0;
		checks = 0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk) #1;
		cmp(count_value, 4'h0);
		cmp(irq, 1'h0);
		foreach (rows[k]) begin
			@(posedge ref_clk);
			preset_data <= rows[k].start;
			preset_load_n <= 1'h0;
			count_down <= rows[k].down;
			#1 cmp(count_value, rows[k].start);
			@(posedge ref_clk);
			preset_load_n <= 1'h1;
			preset_data <= ~rows[k].start;
			pulse();
			cmp(count_value, rows[k].next);
			cmp(terminal_flag, rows[k].term);
		end
		// Hold at fifteen with the enable high; the flag still decodes, the ripple gate stays off until the enable falls.
		@(posedge ref_clk);
		preset_data <= 4'hF;
		preset_load_n <= 1'h0;
		count_down <= 1'h0;
		count_en_n <= 1'h1;
		@(posedge ref_clk) preset_load_n <= 1'h1;
		pulse();
		cmp(count_value, 4'hF);
		cmp(terminal_flag, 1'h1);
		cmp(ripple_clock_n, 1'h1);
		@(posedge ref_clk) count_en_n <= 1'h0;
		#1 cmp(ripple_clock_n, 1'h0);
		@(posedge ref_clk) count_down <= 1'h1;
		#1 cmp(terminal_flag, 1'h0);
		@(posedge ref_clk) count_down <= 1'h0;
		snap = upper_count;
		pulse();
		cmp(count_value, 4'h0);
		cmp(upper_count, 4'(snap + 4'h1));
		// Direction flips on the edge that takes the count, as the count clock falls; only the value before the flip counts.
		@(posedge ref_clk) count_clock <= 1'h1;
		@(posedge ref_clk) count_down <= 1'h1;
		count_clock <= 1'h0;
		@(posedge ref_clk) #1 cmp(count_value, 4'h1);
		@(posedge ref_clk) clk_en <= 1'h0;
		pulse();
		cmp(count_value, 4'h1);
		@(posedge ref_clk) clk_en <= 1'h1;
		axi_wr(`UBC_ADDR_CTRL, 32'h0000_0052, `UBC_RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		cmp(count_value, 4'h5);
		axi_rd(`UBC_ADDR_CTRL, 32'h0000_0050, `UBC_RESP_OKAY);
		axi_rd(`UBC_ADDR_STATUS, 32'h0000_00D5, `UBC_RESP_OKAY);
		axi_rd(32'h0000_0010, 32'h0000_0000, `UBC_RESP_SLVERR);
		axi_wr(32'h0000_0010, 32'h0000_0001, `UBC_RESP_SLVERR);
		axi_rd(`UBC_ADDR_INT_STAT, 32'h0000_0007, `UBC_RESP_OKAY);
		cmp(irq, 1'h0);
		axi_wr(`UBC_ADDR_INT_MASK, 32'h0000_0007, `UBC_RESP_OKAY);
		cmp(irq, 1'h1);
		axi_wr(`UBC_ADDR_INT_STAT, 32'h0000_0007, `UBC_RESP_OKAY);
		cmp(irq, 1'h0);
		axi_wr(`UBC_ADDR_INT_MASK, 32'h0000_0002, `UBC_RESP_OKAY);
		@(posedge ref_clk);
		preset_data <= 4'h0;
		preset_load_n <= 1'h0;
		@(posedge ref_clk) preset_load_n <= 1'h1;
		@(posedge ref_clk) #1 cmp(irq, 1'h0);
		pulse();
		cmp(count_value, 4'hF);
		@(posedge ref_clk) #1 cmp(irq, 1'h1);
		axi_rd(`UBC_ADDR_INT_STAT, 32'h0000_0007, `UBC_RESP_OKAY);
		@(posedge ref_clk) rst <= 1'h1;
		#1 cmp(count_value, 4'h0);
		cmp(irq, 1'h0);
		@(posedge ref_clk) rst <= 1'h0;
		test_done();
	end
endmodule

// ==== tb/ubc_top_asserts.sv ====
// Concurrent checks on the ports of the counter top.
`timescale 1ns/1ps
module ubc_top_asserts (
	input wire logic                ref_clk,        // System clock.
	input wire logic                rst,            // Reset, high.
	input wire logic                clk_en,         // Clock enable.
	input wire logic                count_clock,    // Count clock level.
	input wire logic                count_en_n,     // Count enable, low.
	input wire logic                count_down,     // Direction.
	input wire logic                preset_load_n,  // Preset load, low.
	input wire ubc_pkg::ubc_count_t preset_data,    // Preset value.
	input wire logic [3:0]          count_value,    // Count outputs.
	input wire logic                terminal_flag,  // Terminal count.
	input wire logic                ripple_clock_n, // Ripple clock, low.
	input wire logic                s_axil_awvalid, // Write address valid.
	input wire logic                s_axil_awready, // Write address ready.
	input wire logic                s_axil_wvalid,  // Write data valid.
	input wire logic                s_axil_wready,  // Write data ready.
	input wire logic                s_axil_bvalid,  // Write response valid.
	input wire logic                s_axil_arvalid, // Read address valid.
	input wire logic                s_axil_arready, // Read address ready.
	input wire logic [31:0]         s_axil_rdata,   // Read data.
	input wire logic [1:0]          s_axil_rresp,   // Read response.
	input wire logic                s_axil_rvalid,  // Read data valid.
	input wire logic                s_axil_rready   // Read data ready.
);
	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// A count edge is a sampled rise of the count clock while enabled and not preset.
	sequence cnt_edge;
		clk_en && count_clock && !$past(count_clock) && !count_en_n && preset_load_n;
	endsequence
	sequence wr_taken;
		s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
	endsequence

	chk_preset_mux: assert property (!preset_load_n |-> count_value == preset_data)
		else $error("Count does not follow the preset data.");
	chk_count_up: assert property (cnt_edge ##0 !count_down ##1 preset_load_n
		|-> count_value == 4'($past(count_value) + 4'h1))
		else $error("Up count step is wrong.");
	chk_count_down: assert property (cnt_edge ##0 count_down ##1 preset_load_n
		|-> count_value == 4'($past(count_value) - 4'h1))
		else $error("Down count step is wrong.");
	chk_count_hold: assert property (preset_load_n && $past(preset_load_n)
		&& $past(count_en_n) |-> $stable(count_value))
		else $error("Count moved while disabled.");
	chk_term_decode: assert property (terminal_flag
		== (count_down ? count_value == 4'h0 : count_value == 4'hF))
		else $error("Terminal flag decode is wrong.");
	chk_ripple_gate: assert property (ripple_clock_n
		== !(!count_en_n && terminal_flag && !count_clock))
		else $error("Ripple clock level is wrong.");
	chk_write_resp: assert property (wr_taken |-> ##[1:3] s_axil_bvalid)
		else $error("Write response did not come.");
	chk_read_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
		else $error("Read data did not come.");
	chk_read_hold: assert property (s_axil_rvalid && !s_axil_rready
		|=> s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
		else $error("Read data dropped before taken.");
	chk_read_busy: assert property (s_axil_rvalid |-> !s_axil_arready)
		else $error("Read address accepted while busy.");
endmodule

bind ubc_top ubc_top_asserts chk (.ref_clk, .rst, .clk_en, .count_clock, .count_en_n,
	.count_down, .preset_load_n, .preset_data, .count_value, .terminal_flag,
	.ripple_clock_n, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready,
	.s_axil_bvalid, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
	.s_axil_rvalid, .s_axil_rready);

// ==== tb/ubc_upper_stage.sv ====
// Upper cascade stage model clocked by the ripple clock of the block.
`timescale 1ns/1ps
module ubc_upper_stage (
	input  wire logic       rst,            // Reset, high.
	input  wire logic       ripple_clock_n, // Carry from the lower stage.
	output logic      [3:0] upper_count     // Upper stage count.
);
	// The terminal flag may glitch, so only the ripple clock ever clocks this stage.
	always_ff @(posedge ripple_clock_n or posedge rst) begin
		if (rst) begin
			upper_count <= 4'h0;
		end else begin
			upper_count <= upper_count + 4'h1;
		end
	end
endmodule

// ==== verilog/ubc_cnt_if.sv ====
// Carrier between the register side and the counter core.
`timescale 1ns/1ps
interface ubc_cnt_if;
	logic                sw_inhibit;
	logic                sw_load;
	ubc_pkg::ubc_count_t sw_data;
	ubc_pkg::ubc_count_t count;
	logic                term;
	logic                ripple_n;
	ubc_pkg::ubc_events_s events;

	modport core (
		input  sw_inhibit,
		input  sw_load,
		input  sw_data,
		output count,
		output term,
		output ripple_n,
		output events
	);

	modport ctl (
		output sw_inhibit,
		output sw_load,
		output sw_data,
		input  count,
		input  term,
		input  ripple_n,
		input  events
	);
endinterface

// ==== verilog/ubc_core.sv ====
// Counter core: count register, preset override, terminal and ripple decode.
`timescale 1ns/1ps
`include "ubc_params.svh"
module ubc_core (
	input  wire logic                ref_clk,       // System clock.
	input  wire logic                rst,           // Asynchronous reset, high.
	input  wire logic                clk_en,        // Freezes all state while low.
	input  wire logic                count_clock,   // Count clock pin, level.
	input  wire logic                count_en_n,    // Count enable, low active.
	input  wire logic                count_down,    // Direction, high counts down.
	input  wire logic                preset_load_n, // Preset load, low active.
	input  wire ubc_pkg::ubc_count_t preset_data,   // Parallel preset value.
	ubc_cnt_if.core                  cnt            // Register-side carrier.
);

	ubc_pkg::ubc_count_t cnt_q;
	ubc_pkg::ubc_count_t cnt_d;
	logic                clk_prev_q;
	logic                clk_prev_d;
	logic                term_q;
	logic                term_d;
	logic                rise;
	logic                step;
	ubc_pkg::ubc_count_t shown;

	// ****************************************************************
	// Count register
	// ****************************************************************
	// The count clock is treated as a level sampled on ref_clk, so its
	// rising edge is found by comparing with the previous sample.
	assign rise = count_clock & ~clk_prev_q;
	assign step = rise & ~count_en_n & ~cnt.sw_inhibit;

	always_comb begin
		clk_prev_d = count_clock;
		cnt_d      = cnt_q;
		if (!preset_load_n) begin
			cnt_d = preset_data;
		end else if (cnt.sw_load) begin
			cnt_d = cnt.sw_data;
		end else if (step) begin
			// Natural 4-bit overflow gives the wrap in both directions.
			cnt_d = count_down ? cnt_q - 4'h1 : cnt_q + 4'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q      <= `UBC_CNT_RESET;
			clk_prev_q <= 1'b0;
			term_q     <= 1'b0;
		end else if (clk_en) begin
			cnt_q      <= cnt_d;
			clk_prev_q <= clk_prev_d;
			term_q     <= term_d;
		end
	end

	// ****************************************************************
	// Outputs and events
	// ****************************************************************
	// Preset shows on the outputs at once, not one ref_clk later.
	assign shown     = preset_load_n ? cnt_q : preset_data;
	assign cnt.count = shown;
	// Enable is deliberately absent so a parallel-gated cascade works.
	assign term_d    = count_down ? (shown == `UBC_CNT_MIN) : (shown == `UBC_CNT_MAX);
	assign cnt.term  = term_d;
	assign cnt.ripple_n = ~(~count_en_n & term_d & ~count_clock);

	assign cnt.events.term   = term_d & ~term_q;
	assign cnt.events.wrap   = step & preset_load_n & ~cnt.sw_load & term_d;
	assign cnt.events.preset = ~preset_load_n;

endmodule

// ==== verilog/ubc_irq.sv ====
// Sticky interrupt status with mask and one level output.
`timescale 1ns/1ps
`include "ubc_params.svh"
module ubc_irq (
	input  wire logic                  ref_clk, // System clock.
	input  wire logic                  rst,     // Asynchronous reset, high.
	input  wire logic                  clk_en,  // Freezes all state while low.
	input  wire logic [`UBC_NUM_EV-1:0] events, // Event pulses or levels.
	input  wire logic [`UBC_NUM_EV-1:0] clear,  // Write-one-to-clear strobes.
	input  wire logic [`UBC_NUM_EV-1:0] mask,   // One enables a bit onto irq.
	output logic      [`UBC_NUM_EV-1:0] status, // Sticky status bits.
	output logic                        irq     // Level interrupt.
);

	logic [`UBC_NUM_EV-1:0] st_q;
	logic [`UBC_NUM_EV-1:0] st_d;

	genvar i;
	generate
		for (i = 0; i < `UBC_NUM_EV; i++) begin : g_bit
			// An event in the clearing cycle survives the clear.
			always_comb begin
				st_d[i] = (st_q[i] & ~clear[i]) | events[i];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign status = st_q;
	assign irq    = |(st_q & mask);

endmodule

// ==== verilog/ubc_params.svh ====
// Constants for the up/down binary counter with preset and ripple clock.
`ifndef UBC_PARAMS_SVH
`define UBC_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define UBC_ADDR_CTRL        32'h0000_0000
`define UBC_ADDR_STATUS      32'h0000_0004
`define UBC_ADDR_INT_STAT    32'h0000_0008
`define UBC_ADDR_INT_MASK    32'h0000_000C

// ****************************************************************
// Field positions and values
// ****************************************************************
`define UBC_CTRL_INHIBIT     0
`define UBC_CTRL_LOAD        1
`define UBC_CTRL_PRE_LSB     4
`define UBC_CTRL_PRE_MSB     7
`define UBC_ST_DIR           4
`define UBC_ST_TERM          5
`define UBC_ST_RIPPLE_N      6
`define UBC_ST_PRELOAD_N     7
`define UBC_EV_TERM          0
`define UBC_EV_WRAP          1
`define UBC_EV_PRESET        2
`define UBC_NUM_EV           3
`define UBC_CNT_MAX          4'hF
`define UBC_CNT_MIN          4'h0
`define UBC_CNT_RESET        4'h0
`define UBC_RESP_OKAY        2'h0
`define UBC_RESP_SLVERR      2'h2

`endif

// ==== verilog/ubc_pkg.sv ====
// Types shared by the counter modules.
package ubc_pkg;

	typedef logic [3:0] ubc_count_t;

	typedef struct packed {
		logic preset;
		logic wrap;
		logic term;
	} ubc_events_s;

endpackage

// ==== verilog/ubc_top.sv ====
// Top of the up/down binary counter: pins, AXI4-Lite registers, interrupt.
`timescale 1ns/1ps
`include "ubc_params.svh"
module ubc_top (
	input  wire logic                ref_clk,         // System clock, 25 MHz.
	input  wire logic                rst,             // Asynchronous reset, high.
	input  wire logic                clk_en,          // Freezes all state while low.
	input  wire logic                count_clock,     // Count clock, rising edge counts.
	input  wire logic                count_en_n,      // Count enable, low active.
	input  wire logic                count_down,      // Direction, high counts down.
	input  wire logic                preset_load_n,   // Preset load, low active.
	input  wire ubc_pkg::ubc_count_t preset_data,     // Parallel preset value.
	output logic      [3:0]          count_value,     // Count outputs.
	output logic                     terminal_flag,   // Terminal count, high.
	output logic                     ripple_clock_n,  // Ripple clock, low active.
	output logic                     irq,             // Interrupt, level high.
	input  wire logic [31:0]         s_axil_awaddr,   // Write address.
	input  wire logic                s_axil_awvalid,  // Write address valid.
	output logic                     s_axil_awready,  // Write address ready.
	input  wire logic [31:0]         s_axil_wdata,    // Write data.
	input  wire logic [3:0]          s_axil_wstrb,    // Write strobes.
	input  wire logic                s_axil_wvalid,   // Write data valid.
	output logic                     s_axil_wready,   // Write data ready.
	output logic      [1:0]          s_axil_bresp,    // Write response.
	output logic                     s_axil_bvalid,   // Write response valid.
	input  wire logic                s_axil_bready,   // Write response ready.
	input  wire logic [31:0]         s_axil_araddr,   // Read address.
	input  wire logic                s_axil_arvalid,  // Read address valid.
	output logic                     s_axil_arready,  // Read address ready.
	output logic      [31:0]         s_axil_rdata,    // Read data.
	output logic      [1:0]          s_axil_rresp,    // Read response.
	output logic                     s_axil_rvalid,   // Read data valid.
	input  wire logic                s_axil_rready    // Read data ready.
);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	// Returns a one-hot select: ctrl, status, int_stat, int_mask.
	function automatic logic [3:0] reg_sel(input logic [31:0] addr);
		logic [3:0] sel;
		sel = 4'h0;
		if (addr == `UBC_ADDR_CTRL) begin
			sel = 4'h1;
		end else if (addr == `UBC_ADDR_STATUS) begin
			sel = 4'h2;
		end else if (addr == `UBC_ADDR_INT_STAT) begin
			sel = 4'h4;
		end else if (addr == `UBC_ADDR_INT_MASK) begin
			sel = 4'h8;
		end
		return sel;
	endfunction

	ubc_cnt_if cnt ();

	logic                   aw_held_q;
	logic                   aw_held_d;
	logic [31:0]            aw_addr_q;
	logic [31:0]            aw_addr_d;
	logic                   w_held_q;
	logic                   w_held_d;
	logic [31:0]            w_data_q;
	logic [31:0]            w_data_d;
	logic [3:0]             w_strb_q;
	logic [3:0]             w_strb_d;
	logic                   bvalid_q;
	logic                   bvalid_d;
	logic [1:0]             bresp_q;
	logic [1:0]             bresp_d;
	logic                   rvalid_q;
	logic                   rvalid_d;
	logic [31:0]            rdata_q;
	logic [31:0]            rdata_d;
	logic [1:0]             rresp_q;
	logic [1:0]             rresp_d;
	logic                   do_wr;
	logic [3:0]             wsel;
	logic [3:0]             rsel;
	logic                   lane0;

	logic                   inhibit_q;
	logic                   inhibit_d;
	ubc_pkg::ubc_count_t    pre_q;
	ubc_pkg::ubc_count_t    pre_d;
	logic                   load_q;
	logic                   load_d;
	logic [`UBC_NUM_EV-1:0] mask_q;
	logic [`UBC_NUM_EV-1:0] mask_d;
	logic [`UBC_NUM_EV-1:0] int_clear;
	logic [`UBC_NUM_EV-1:0] int_status;
	logic [31:0]            status_word;

	// ****************************************************************
	// Write channel
	// ****************************************************************
	// Address and data are held separately so either may arrive first;
	// a new pair is refused until the response has been taken.
	assign s_axil_awready = clk_en & ~aw_held_q & ~bvalid_q;
	assign s_axil_wready  = clk_en & ~w_held_q & ~bvalid_q;
	assign do_wr          = aw_held_q & w_held_q & ~bvalid_q;
	assign wsel           = reg_sel(aw_addr_q);
	assign lane0          = w_strb_q[0];

	always_comb begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d  = w_held_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		if (s_axil_awvalid && s_axil_awready) begin
			aw_held_d = 1'b1;
			aw_addr_d = s_axil_awaddr;
		end
		if (s_axil_wvalid && s_axil_wready) begin
			w_held_d = 1'b1;
			w_data_d = s_axil_wdata;
			w_strb_d = s_axil_wstrb;
		end
		if (do_wr) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = (wsel == 4'h0) ? `UBC_RESP_SLVERR : `UBC_RESP_OKAY;
		end else if (bvalid_q && s_axil_bready) begin
			bvalid_d = 1'b0;
		end
	end

	// ****************************************************************
	// Registers written by software
	// ****************************************************************
	always_comb begin
		inhibit_d = inhibit_q;
		pre_d     = pre_q;
		load_d    = 1'b0;
		mask_d    = mask_q;
		int_clear = '0;
		if (do_wr && lane0) begin
			if (wsel[0]) begin
				inhibit_d = w_data_q[`UBC_CTRL_INHIBIT];
				pre_d     = w_data_q[`UBC_CTRL_PRE_MSB:`UBC_CTRL_PRE_LSB];
				load_d    = w_data_q[`UBC_CTRL_LOAD];
			end else if (wsel[2]) begin
				int_clear = w_data_q[`UBC_NUM_EV-1:0];
			end else if (wsel[3]) begin
				mask_d = w_data_q[`UBC_NUM_EV-1:0];
			end
		end
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	assign s_axil_arready = clk_en & ~rvalid_q;
	assign rsel           = reg_sel(s_axil_araddr);

	always_comb begin
		status_word                      = 32'h0000_0000;
		status_word[3:0]                 = cnt.count;
		status_word[`UBC_ST_DIR]         = count_down;
		status_word[`UBC_ST_TERM]        = cnt.term;
		status_word[`UBC_ST_RIPPLE_N]    = cnt.ripple_n;
		status_word[`UBC_ST_PRELOAD_N]   = preset_load_n;
	end

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axil_arvalid && s_axil_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = `UBC_RESP_OKAY;
			rdata_d  = 32'h0000_0000;
			if (rsel[0]) begin
				rdata_d[`UBC_CTRL_INHIBIT]                   = inhibit_q;
				rdata_d[`UBC_CTRL_PRE_MSB:`UBC_CTRL_PRE_LSB] = pre_q;
			end else if (rsel[1]) begin
				rdata_d = status_word;
			end else if (rsel[2]) begin
				rdata_d[`UBC_NUM_EV-1:0] = int_status;
			end else if (rsel[3]) begin
				rdata_d[`UBC_NUM_EV-1:0] = mask_q;
			end else begin
				rresp_d = `UBC_RESP_SLVERR;
			end
		end else if (rvalid_q && s_axil_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `UBC_RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `UBC_RESP_OKAY;
			inhibit_q <= 1'b0;
			pre_q     <= `UBC_CNT_RESET;
			load_q    <= 1'b0;
			mask_q    <= '0;
		end else if (clk_en) begin
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q  <= w_held_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			inhibit_q <= inhibit_d;
			pre_q     <= pre_d;
			load_q    <= load_d;
			mask_q    <= mask_d;
		end
	end

	assign s_axil_bvalid = bvalid_q;
	assign s_axil_bresp  = bresp_q;
	assign s_axil_rvalid = rvalid_q;
	assign s_axil_rdata  = rdata_q;
	assign s_axil_rresp  = rresp_q;

	// ****************************************************************
	// Counter core and interrupt
	// ****************************************************************
	// The pin preset still wins over a software load in the same cycle.
	assign cnt.sw_inhibit = inhibit_q;
	assign cnt.sw_load    = load_q;
	assign cnt.sw_data    = pre_q;

	ubc_core u_core (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.clk_en        (clk_en),
		.count_clock   (count_clock),
		.count_en_n    (count_en_n),
		.count_down    (count_down),
		.preset_load_n (preset_load_n),
		.preset_data   (preset_data),
		.cnt           (cnt.core)
	);

	ubc_irq u_irq (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.events  (cnt.events),
		.clear   (int_clear),
		.mask    (mask_q),
		.status  (int_status),
		.irq     (irq)
	);

	assign count_value    = cnt.count;
	assign terminal_flag  = cnt.term;
	assign ripple_clock_n = cnt.ripple_n;

endmodule
